/* logic/pcc_consts.vh */
/*
 * Constants of the pixel clock configuration checker: frequency limits
 * in hertz, field codes and state codes.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// Low-jitter path: divided reference window, 625 kHz .. 2.5 MHz
`define PCC_LJ_REF_LO_HZ 64'h0000000000098968
`define PCC_LJ_REF_HI_HZ 64'h00000000002625A0
// Low-jitter path: oscillator window, 750 MHz .. 2.5 GHz
`define PCC_LJ_OSC_LO_HZ 64'h000000002CB41780
`define PCC_LJ_OSC_HI_HZ 64'h000000009502F900
// Oscillator range select threshold, 1250 MHz
`define PCC_OSC_SPLIT_HZ 64'h000000004A817C80
// Sigma-delta divider step, 250 MHz
`define PCC_SD_STEP_HZ 64'h000000000EE6B280
// Sideband path: divided reference floor, 150 kHz
`define PCC_SB_REF_LO_HZ 64'h00000000000249F0
// Sideband path: oscillator window, 40 MHz .. 2.8 GHz
`define PCC_SB_OSC_LO_HZ 64'h0000000002625A00
`define PCC_SB_OSC_HI_HZ 64'h00000000A6E49C00
// Logic clock ceiling, 165 MHz
`define PCC_LCLK_MAX_HZ 64'h0000000009D5B340

// Oscillator range select codes
`define PCC_OSC_RANGE_LOW 3'h2
`define PCC_OSC_RANGE_HIGH 3'h4

// Clock source codes
`define PCC_SRC_LOW_JITTER 2'h0
`define PCC_SRC_SIDEBAND 2'h1
`define PCC_SRC_SPARE_STORAGE 2'h2
`define PCC_SRC_SPARE_EXPANSION 2'h3

// Error cause bit positions
`define PCC_ERR_REF 0
`define PCC_ERR_OSC 1
`define PCC_ERR_LCLK 2
`define PCC_ERR_SPARE 3
`define PCC_ERR_ZERO 4
`define PCC_ERR_W 5

// Divider iteration count
`define PCC_DIV_STEPS 7'h40

// Sequencer states
`define PCC_ST_IDLE 3'h0
`define PCC_ST_CHECK 3'h1
`define PCC_ST_SD 3'h2
`define PCC_ST_SD_WAIT 3'h3
`define PCC_ST_PIX 3'h4
`define PCC_ST_PIX_WAIT 3'h5
`define PCC_ST_DONE 3'h6

`endif

/* logic/pcc_divider.v */
/*
 * Iterative 64-bit unsigned restoring divider, one quotient bit a cycle.
 * Assumes the caller never starts it with a zero denominator and holds
 * no new start while it runs.
 */
`timescale 1ns/1ps
`include "pcc_consts.vh"

module pcc_divider (
	input wire clk_sys,
	input wire reset,
	input wire start,
	input wire [63:0] numer,
	input wire [63:0] denom,
	output reg done,
	output reg [63:0] quot
);

	reg [6:0] cnt_q; // Remaining steps
	reg run_q; // Division in progress
	reg [63:0] rem_q; // Partial remainder
	reg [63:0] den_q; // Latched denominator
	wire [64:0] rem_sh; // Remainder shifted with next numerator bit
	wire take; // Trial subtraction fits
	wire [64:0] rem_sub; // Remainder after subtraction

	assign rem_sh = {rem_q, quot[63]};
	assign take = (rem_sh >= {1'b0, den_q});
	assign rem_sub = rem_sh - {1'b0, den_q};

	// Shift-subtract loop; quotient builds in place of the numerator
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_q <= 7'h00;
			run_q <= 1'b0;
			rem_q <= 64'h0000000000000000;
			den_q <= 64'h0000000000000000;
			quot <= 64'h0000000000000000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				// Load operands
				cnt_q <= `PCC_DIV_STEPS;
				run_q <= 1'b1;
				rem_q <= 64'h0000000000000000;
				den_q <= denom;
				quot <= numer;
			end else if (run_q) begin
				// One quotient bit
				rem_q <= take ? rem_sub[63:0] : rem_sh[63:0];
				quot <= {quot[62:0], take};
				cnt_q <= cnt_q - 7'h01;
				if (cnt_q == 7'h01) begin
					run_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule

/* logic/pcc_pixel_clock_cfg.v */
/*
 * Pixel clock path configuration checker: takes a requested source,
 * pre-divider, multiplier and divider chain, checks the legal windows,
 * derives the oscillator range select and sigma-delta divider fields,
 * computes the pixel clock and commits the settings or refuses them.
 * Assumes all inputs come from logic on clk_sys and stay stable from
 * the apply pulse until done.
 */
`timescale 1ns/1ps
`include "pcc_consts.vh"

module pcc_pixel_clock_cfg (
	input wire clk_sys,
	input wire reset,
	input wire apply, // One-cycle request to check and commit
	input wire [1:0] req_source, // Clock source code
	input wire [31:0] req_ref_hz, // Reference oscillator in Hz
	input wire [7:0] req_pre_div, // Pre-divider field (divides by value+1)
	input wire [11:0] req_mult, // Multiplier field
	input wire [4:0] req_post_div, // Low-jitter post-divider
	input wire [4:0] req_hs_div, // Sideband fast divider (divides by value+1)
	input wire [7:0] req_lclk_div, // Logic clock divider
	input wire [7:0] req_pclk_div, // Pixel clock divider
	input wire storage_in_use, // Serial storage interface active
	input wire expansion_in_use, // Expansion interface active
	input wire link_rx_enabled, // Far-end deserializer has been enabled
	input wire ser_out_en, // Serializer output enable
	output reg busy, // Check in progress
	output reg done, // One-cycle end of a check
	output reg cfg_error, // Last request was refused
	output reg [`PCC_ERR_W-1:0] err_cause, // Causes of the last refusal
	output reg [1:0] source, // Committed source
	output reg [7:0] pre_div, // Committed pre-divider
	output reg [11:0] mult, // Committed multiplier
	output reg [4:0] post_div, // Committed post-divider
	output reg [4:0] hs_div, // Committed fast divider
	output reg [7:0] lclk_div, // Committed logic clock divider
	output reg [7:0] pclk_div, // Committed pixel clock divider
	output reg [2:0] oscillator_range_select, // Derived range field
	output reg [7:0] sigma_delta_divider, // Derived sigma-delta field
	output reg [31:0] pixel_hz, // Committed pixel clock in Hz
	output reg duty_ok, // Committed chain gives 50% duty
	output reg [19:0] jitter_rank, // Sideband {pre-div, mult}, larger is better
	output reg eq_reset_req // One-cycle request to reset far equalizer
);

	reg [2:0] state_q; // Sequencer state
	reg [2:0] state_d; // Next sequencer state
	reg [1:0] c_src; // Captured request fields
	reg [31:0] c_ref;
	reg [7:0] c_n;
	reg [11:0] c_m;
	reg [4:0] c_m2;
	reg [4:0] c_m4;
	reg [7:0] c_lcd;
	reg [7:0] c_pcd;
	reg [7:0] sd_q; // Sigma-delta result awaiting commit
	reg [2:0] osc_sel_q; // Range select awaiting commit
	reg duty_q; // Duty check awaiting commit
	reg ser_en_q; // Previous serializer enable, for edge
	reg committed_q; // A configuration has been committed once
	reg div_start; // Divider start pulse
	reg [63:0] div_num; // Divider numerator
	reg [63:0] div_den; // Divider denominator
	wire div_done; // Divider finished
	wire [63:0] div_quot; // Divider quotient

	wire is_lj; // Request follows low-jitter rules
	wire [63:0] ref64; // Reference widened
	wire [63:0] np1; // Pre-divider plus one
	wire [63:0] num_lj; // Reference times multiplier
	wire [63:0] osc; // Oscillator times (N+1), per path
	wire [63:0] chain_den; // (N+1) times dividers up to logic clock
	wire [63:0] pix_den; // Full pixel divider product
	wire [63:0] sd_den; // (N+1) times sigma-delta step
	wire ref_ok; // Divided reference window met
	wire osc_ok; // Oscillator window met
	wire lclk_ok; // Logic clock ceiling met
	wire spare_ok; // Spare PLL free to use
	wire zero_ok; // No zero divider
	wire [`PCC_ERR_W-1:0] cause; // Collected refusal causes
	wire [2:0] chain; // Dividers in order: post, logic, pixel
	wire [2:0] even; // Divider is even
	wire [2:0] one; // Divider equals one
	wire [2:0] pos_ok; // Per-position duty condition
	wire duty_now; // Duty condition for the captured chain

	assign is_lj = (c_src != `PCC_SRC_SIDEBAND);
	assign ref64 = {32'h00000000, c_ref};
	assign np1 = {56'h00000000000000, c_n} + 64'h0000000000000001;
	assign num_lj = ref64 * {52'h0000000000000, c_m};
	// Sideband oscillator runs at twice the multiplier
	assign osc = is_lj ? num_lj : {num_lj[62:0], 1'b0};
	assign chain_den = np1 * (is_lj ? {59'h000000000000000, c_m2} :
		({59'h000000000000000, c_m4} + 64'h0000000000000001)) *
		{56'h00000000000000, c_lcd};
	assign pix_den = chain_den * {56'h00000000000000, c_pcd};
	assign sd_den = np1 * `PCC_SD_STEP_HZ;

	assign ref_ok = is_lj ?
		((ref64 > `PCC_LJ_REF_LO_HZ * np1) && (ref64 < `PCC_LJ_REF_HI_HZ * np1)) :
		(ref64 > `PCC_SB_REF_LO_HZ * np1);
	assign osc_ok = is_lj ?
		((osc > `PCC_LJ_OSC_LO_HZ * np1) && (osc < `PCC_LJ_OSC_HI_HZ * np1)) :
		((osc > `PCC_SB_OSC_LO_HZ * np1) && (osc < `PCC_SB_OSC_HI_HZ * np1));
	// logic clock ceiling, cross-multiplied to avoid a division
	assign lclk_ok = (osc <= `PCC_LCLK_MAX_HZ * chain_den);
	// spare PLL only with its own interface idle
	assign spare_ok = !((c_src == `PCC_SRC_SPARE_STORAGE) && storage_in_use) &&
		!((c_src == `PCC_SRC_SPARE_EXPANSION) && expansion_in_use);
	// Zero dividers would make the chain meaningless
	assign zero_ok = (c_lcd != 8'h00) && (c_pcd != 8'h00) &&
		(!is_lj || (c_m2 != 5'h00));

	assign cause = {!zero_ok, !spare_ok, !lclk_ok, !osc_ok, !ref_ok};

	// Chain positions; the sideband path has no post-divider, so one stands in
	assign chain[0] = is_lj ? c_m2[0] : 1'b1;
	assign chain[1] = c_lcd[0];
	assign chain[2] = c_pcd[0];
	assign one[0] = is_lj ? (c_m2 == 5'h01) : 1'b1;
	assign one[1] = (c_lcd == 8'h01);
	assign one[2] = (c_pcd == 8'h01);

	// each divider even, one, or followed by an even one
	// same test on the sideband logic and pixel dividers
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_duty
			assign even[gi] = !chain[gi];
			if (gi == 2) begin : g_last
				assign pos_ok[gi] = even[gi] || one[gi];
			end else begin : g_mid
				assign pos_ok[gi] = even[gi] || one[gi] || (|even[2:gi+1]);
			end
		end
	endgenerate
	assign duty_now = &pos_ok;

	pcc_divider u_div (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(div_start),
		.numer(div_num),
		.denom(div_den),
		.done(div_done),
		.quot(div_quot)
	);

	// Next state of the sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			`PCC_ST_IDLE: begin
				if (apply) begin
					state_d = `PCC_ST_CHECK;
				end
			end
			`PCC_ST_CHECK: begin
				// any violation ends the check here
				if (cause != {`PCC_ERR_W{1'b0}}) begin
					state_d = `PCC_ST_DONE;
				end else if (is_lj) begin
					state_d = `PCC_ST_SD;
				end else begin
					state_d = `PCC_ST_PIX;
				end
			end
			`PCC_ST_SD: state_d = `PCC_ST_SD_WAIT;
			`PCC_ST_SD_WAIT: begin
				if (div_done) begin
					state_d = `PCC_ST_PIX;
				end
			end
			`PCC_ST_PIX: state_d = `PCC_ST_PIX_WAIT;
			`PCC_ST_PIX_WAIT: begin
				if (div_done) begin
					state_d = `PCC_ST_DONE;
				end
			end
			`PCC_ST_DONE: state_d = `PCC_ST_IDLE;
			default: state_d = `PCC_ST_IDLE;
		endcase
	end

	// Divider operands per phase
	always @* begin
		div_start = 1'b0;
		div_num = 64'h0000000000000000;
		div_den = 64'h0000000000000001;
		case (state_q)
			`PCC_ST_SD: begin
				// ceiling by adding denominator minus one
				div_start = 1'b1;
				div_num = num_lj + sd_den - 64'h0000000000000001;
				div_den = sd_den;
			end
			`PCC_ST_PIX: begin
				// low-jitter chain over (N+1), post, logic, pixel
				// sideband chain with doubled multiplier and fast divider
				div_start = 1'b1;
				div_num = osc;
				div_den = pix_den;
			end
			default: begin
				div_start = 1'b0;
			end
		endcase
	end

	// Sequencer, capture, commit and status
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= `PCC_ST_IDLE;
			c_src <= `PCC_SRC_LOW_JITTER;
			c_ref <= 32'h00000000;
			c_n <= 8'h00;
			c_m <= 12'h000;
			c_m2 <= 5'h00;
			c_m4 <= 5'h00;
			c_lcd <= 8'h00;
			c_pcd <= 8'h00;
			sd_q <= 8'h00;
			osc_sel_q <= `PCC_OSC_RANGE_LOW;
			duty_q <= 1'b0;
			ser_en_q <= 1'b0;
			committed_q <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			cfg_error <= 1'b0;
			err_cause <= {`PCC_ERR_W{1'b0}};
			source <= `PCC_SRC_LOW_JITTER;
			pre_div <= 8'h00;
			mult <= 12'h000;
			post_div <= 5'h00;
			hs_div <= 5'h00;
			lclk_div <= 8'h00;
			pclk_div <= 8'h00;
			oscillator_range_select <= `PCC_OSC_RANGE_LOW;
			sigma_delta_divider <= 8'h00;
			pixel_hz <= 32'h00000000;
			duty_ok <= 1'b0;
			jitter_rank <= 20'h00000;
			eq_reset_req <= 1'b0;
		end else begin
			state_q <= state_d;
			done <= 1'b0;
			ser_en_q <= ser_out_en;
			// serializer output switched on after the far end is up
			eq_reset_req <= link_rx_enabled && ser_out_en && !ser_en_q;
			busy <= (state_d != `PCC_ST_IDLE);
			case (state_q)
				`PCC_ST_IDLE: begin
					if (apply) begin
						// Capture the request
						c_src <= req_source;
						c_ref <= req_ref_hz;
						c_n <= req_pre_div;
						c_m <= req_mult;
						c_m2 <= req_post_div;
						c_m4 <= req_hs_div;
						c_lcd <= req_lclk_div;
						c_pcd <= req_pclk_div;
					end
				end
				`PCC_ST_CHECK: begin
					err_cause <= cause;
					duty_q <= duty_now;
					sd_q <= 8'h00;
					// range select from reference times multiplier over (N+1) against 1250 MHz
					osc_sel_q <= (num_lj < `PCC_OSC_SPLIT_HZ * np1) ?
						`PCC_OSC_RANGE_LOW : `PCC_OSC_RANGE_HIGH;
					if (cause != {`PCC_ERR_W{1'b0}}) begin
						// refuse and leave committed settings alone
						cfg_error <= 1'b1;
					end
				end
				`PCC_ST_SD_WAIT: begin
					if (div_done) begin
						sd_q <= div_quot[7:0];
					end
				end
				`PCC_ST_PIX_WAIT: begin
					if (div_done) begin
						// Commit the whole checked configuration at once
						cfg_error <= 1'b0;
						source <= c_src;
						pre_div <= c_n;
						mult <= c_m;
						post_div <= c_m2;
						hs_div <= c_m4;
						lclk_div <= c_lcd;
						pclk_div <= c_pcd;
						oscillator_range_select <= osc_sel_q;
						sigma_delta_divider <= sd_q;
						pixel_hz <= div_quot[31:0];
						duty_ok <= duty_q;
						committed_q <= 1'b1;
						// rank orders pre-divider first, multiplier second
						jitter_rank <= is_lj ? 20'h00000 : {c_n, c_m};
						// pixel clock frequency change while far end is up
						if (link_rx_enabled && committed_q &&
							(div_quot[31:0] != pixel_hz)) begin
							eq_reset_req <= 1'b1;
						end
					end
				end
				`PCC_ST_DONE: begin
					done <= 1'b1;
				end
				default: begin
					done <= 1'b0;
				end
			endcase
		end
	end

endmodule

/* tb/pcc_cfg_checker.sv */
/* Checker of the pixel clock configuration block: request timing and
   relations among committed fields.
   Assumes it is bound to the block's top module. */
`timescale 1ns/1ps
`include "pcc_consts.vh"
module pcc_cfg_checker (
	input logic clk_sys,
	input logic reset,
	input logic apply,
	input logic busy,
	input logic done,
	input logic cfg_error,
	input logic [4:0] err_cause,
	input logic [1:0] source,
	input logic [7:0] pre_div,
	input logic [11:0] mult,
	input logic [7:0] pclk_div,
	input logic [2:0] oscillator_range_select,
	input logic [7:0] sigma_delta_divider,
	input logic [31:0] pixel_hz,
	input logic [19:0] jitter_rank,
	input logic link_rx_enabled,
	input logic ser_out_en,
	input logic eq_reset_req
);
	// One clock domain, quiet in reset
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_take; apply && !busy |=> busy; endproperty
	a_take: assert property (p_take) else $error("request not taken");
	property p_end; $rose(busy) |-> ##[1:140] done; endproperty
	a_end: assert property (p_end) else $error("no done");
	property p_fall; done |-> (!busy && $past(busy)) ##1 !done; endproperty
	a_fall: assert property (p_fall) else $error("bad done shape");
	property p_flag; done |-> cfg_error == (err_cause != 5'h00); endproperty
	a_flag: assert property (p_flag) else $error("flag and cause differ");
	property p_quick; done && cfg_error |-> !$past(busy, 3); endproperty
	a_quick: assert property (p_quick) else $error("slow refusal");
	property p_keep; done && cfg_error |->
		pixel_hz == $past(pixel_hz, 2) && mult == $past(mult, 2); endproperty
	a_keep: assert property (p_keep) else $error("refusal changed settings");
	property p_lclk; done && !cfg_error |->
		64'(pixel_hz) * pclk_div <= `PCC_LCLK_MAX_HZ; endproperty
	a_lclk: assert property (p_lclk) else $error("logic clock too fast");
	property p_range; done && !cfg_error && source != `PCC_SRC_SIDEBAND |->
		(oscillator_range_select == `PCC_OSC_RANGE_LOW) ? sigma_delta_divider <= 8'h05 :
		(oscillator_range_select == `PCC_OSC_RANGE_HIGH && sigma_delta_divider >= 8'h05);
	endproperty
	a_range: assert property (p_range) else $error("range and divider disagree");
	property p_rank; done && !cfg_error && source == `PCC_SRC_SIDEBAND |->
		jitter_rank == {pre_div, mult} && sigma_delta_divider == 8'h00; endproperty
	a_rank: assert property (p_rank) else $error("bad sideband rank");
	property p_hint; link_rx_enabled && $rose(ser_out_en) |-> ##[1:2] eq_reset_req; endproperty
	a_hint: assert property (p_hint) else $error("no equalizer hint");
	property p_hint_src; eq_reset_req |-> $past(link_rx_enabled); endproperty
	a_hint_src: assert property (p_hint_src) else $error("equalizer hint without link");
endmodule
bind pcc_pixel_clock_cfg pcc_cfg_checker chk_u (.clk_sys, .reset, .apply, .busy, .done,
	.cfg_error, .err_cause, .source, .pre_div, .mult, .pclk_div, .oscillator_range_select,
	.sigma_delta_divider, .pixel_hz, .jitter_rank, .link_rx_enabled, .ser_out_en,
	.eq_reset_req);

/* tb/pcc_link_model.sv */
/* Far-end link model: freshness of the deserializer equalizer.
   Assumes the host writes the equalizer reset when hinted. */
`timescale 1ns/1ps
module pcc_link_model (
	input logic clk_sys,
	input logic reset,
	input logic [31:0] pixel_hz,
	input logic link_rx_enabled,
	input logic ser_out_en,
	input logic eq_reset_wr,
	output logic stale_q
);
	logic [31:0] hz_q; // Pixel clock seen last cycle
	logic en_q; // Output enable seen last cycle
	// stale on change, fresh on reset write
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hz_q <= 32'h0;
			en_q <= 1'b0;
			stale_q <= 1'b0;
		end else begin
			hz_q <= pixel_hz;
			en_q <= ser_out_en;
			if (eq_reset_wr)
				stale_q <= 1'b0;
			else if (link_rx_enabled && (pixel_hz != hz_q || ser_out_en && !en_q))
				stale_q <= 1'b1;
		end
	end
endmodule

/* tb/pcc_pixel_clock_cfg_tb.sv */
/* Bench of the pixel clock configuration block: boundary and random
   requests checked through a queue, plus the far-end link model.
   Assumes the block and its header are compiled alongside. */
`timescale 1ns/1ps
`include "pcc_consts.vh"
module pcc_pixel_clock_cfg_tb;
	localparam logic [31:0] REF = 32'h01312D00; // Reference, 20 MHz
	logic clk_sys = 1'b0, reset = 1'b1, apply = 1'b0; // Clock, reset, request
	logic [1:0] req_source = 2'h0; // Requested fields
	logic [31:0] req_ref_hz = 32'h0;
	logic [7:0] req_pre_div = 8'h00, req_lclk_div = 8'h00, req_pclk_div = 8'h00;
	logic [11:0] req_mult = 12'h000;
	logic [4:0] req_post_div = 5'h00, req_hs_div = 5'h00;
	logic storage_in_use = 1'b0, expansion_in_use = 1'b0; // Spare interfaces
	logic link_rx_enabled = 1'b0, ser_out_en = 1'b0; // Far link state
	logic busy, done, cfg_error, duty_ok, eq_reset_req, stale_q; // Outputs
	logic [4:0] err_cause, post_div, hs_div;
	logic [1:0] source;
	logic [7:0] pre_div, lclk_div, pclk_div, sigma_delta_divider;
	logic [11:0] mult;
	logic [2:0] oscillator_range_select;
	logic [31:0] pixel_hz, e_pix = 32'h0, rnd = 32'h20085EA5; // e_ are expected commits
	logic [19:0] jitter_rank;
	logic [2:0] e_rng = 3'h2;
	logic [7:0] e_sd = 8'h00;
	logic e_duty = 1'b0;
	logic [67:0] e_cfg = 68'h0; // Expected committed fields and rank
	logic [117:0] exq[$]; // Pending results
	int fail_count = 0, total_checks = 0, cycles = 0;
	pcc_pixel_clock_cfg dut_u (.clk_sys, .reset, .apply, .req_source, .req_ref_hz, .req_pre_div,
		.req_mult, .req_post_div, .req_hs_div, .req_lclk_div, .req_pclk_div, .storage_in_use,
		.expansion_in_use, .link_rx_enabled, .ser_out_en, .busy, .done, .cfg_error, .err_cause,
		.source, .pre_div, .mult, .post_div, .hs_div, .lclk_div, .pclk_div,
		.oscillator_range_select, .sigma_delta_divider, .pixel_hz, .duty_ok, .jitter_rank,
		.eq_reset_req);
	// Host forwards the hint as the equalizer reset write
	pcc_link_model link_u (.clk_sys, .reset, .pixel_hz, .link_rx_enabled, .ser_out_en,
		.eq_reset_wr(eq_reset_req), .stale_q);
	initial forever #4 clk_sys = ~clk_sys;
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Works out the outcome, then issues the request and an ignored repeat
	task automatic send(input logic [1:0] s, input logic [31:0] r, input logic [7:0] n,
		input logic [11:0] m, input logic [4:0] m2, input logic [4:0] hs, input logic [7:0] logic_clock_divider,
		input logic [7:0] pixel_clock_divider, input logic su, input logic eu);
		logic [63:0] n1, rm, osc, dv;
		logic [4:0] c;
		logic sb;
		sb = s == `PCC_SRC_SIDEBAND;
		n1 = 64'(n) + 64'h1;
		rm = 64'(r) * m;
		osc = sb ? rm << 1 : rm;
		dv = n1 * (sb ? 64'(hs) + 64'h1 : 64'(m2)) * logic_clock_divider;
		c[0] = sb ? r <= `PCC_SB_REF_LO_HZ * n1
			: r <= `PCC_LJ_REF_LO_HZ * n1 || r >= `PCC_LJ_REF_HI_HZ * n1;
		c[1] = sb ? osc <= `PCC_SB_OSC_LO_HZ * n1 || osc >= `PCC_SB_OSC_HI_HZ * n1
			: osc <= `PCC_LJ_OSC_LO_HZ * n1 || osc >= `PCC_LJ_OSC_HI_HZ * n1;
		c[2] = osc > `PCC_LCLK_MAX_HZ * dv;
		c[3] = s == `PCC_SRC_SPARE_STORAGE && su || s == `PCC_SRC_SPARE_EXPANSION && eu;
		c[4] = logic_clock_divider == 8'h00 || pixel_clock_divider == 8'h00 || !sb && m2 == 5'h00;
		if (c == 5'h00) begin
			e_pix = 32'(osc / (dv * pixel_clock_divider));
			e_rng = rm < `PCC_OSC_SPLIT_HZ * n1 ? `PCC_OSC_RANGE_LOW : `PCC_OSC_RANGE_HIGH;
			e_sd = sb ? 8'h00 : 8'((rm + `PCC_SD_STEP_HZ * n1 - 64'h1) / (`PCC_SD_STEP_HZ * n1));
			e_duty = (pixel_clock_divider == 8'h01 || !pixel_clock_divider[0]) && (logic_clock_divider == 8'h01 || !logic_clock_divider[0] || !pixel_clock_divider[0])
				&& (sb || m2 == 5'h01 || !m2[0] || !logic_clock_divider[0] || !pixel_clock_divider[0]);
			e_cfg = {s, n, m, m2, hs, logic_clock_divider, pixel_clock_divider, sb ? {n, m} : 20'h00000};
		end
		@(negedge clk_sys);
		{req_source, req_ref_hz, req_pre_div, req_mult, req_post_div} = {s, r, n, m, m2};
		{req_hs_div, req_lclk_div, req_pclk_div} = {hs, logic_clock_divider, pixel_clock_divider};
		{storage_in_use, expansion_in_use, apply} = {su, eu, 1'b1};
		exq.push_back({e_cfg, c != 5'h00, c, e_pix, e_rng, e_sd, e_duty});
		@(negedge clk_sys) apply = 1'b0;
		@(negedge clk_sys) apply = 1'b1;
		@(negedge clk_sys) apply = 1'b0;
		for (int i = 0; i < 200 && done !== 1'b1; i++)
			@(negedge clk_sys);
	endtask
	// Compare each finished request with the oldest expectation
	always @(posedge clk_sys) begin
		logic [67:0] ec;
		logic [49:0] e;
		if (done === 1'b1) begin
			if (exq.size() == 0)
				chk("extra done", 32'h1, 32'h0);
			else begin
				{ec, e} = exq.pop_front();
				chk("cfg_error", 32'(cfg_error), 32'(e[49]));
				chk("err_cause", 32'(err_cause), 32'(e[48:44]));
				chk("pixel_hz", pixel_hz, e[43:12]);
				chk("range", 32'(oscillator_range_select), 32'(e[11:9]));
				chk("sigma_delta", 32'(sigma_delta_divider), 32'(e[8:1]));
				chk("duty_ok", 32'(duty_ok), 32'(e[0]));
				chk("source", 32'(source), 32'(ec[67:66]));
				chk("pre_mult", 32'({pre_div, mult}), 32'(ec[65:46]));
				chk("dividers", 32'({post_div, hs_div, lclk_div, pclk_div}), 32'(ec[45:20]));
				chk("jitter_rank", 32'(jitter_rank), 32'(ec[19:0]));
			end
		end
	end
	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 12000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(negedge clk_sys);
		reset = 1'b0;
		send(2'h0, REF, 8'h17, 12'hA1E, 5'h1C, 5'h00, 8'h01, 8'h01, 1'b0, 1'b0);
		link_rx_enabled = 1'b1;
		send(2'h0, REF, 8'h18, 12'h406, 5'h0A, 5'h00, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h1, REF, 8'h6F, 12'h707, 5'h00, 5'h09, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h0, REF, 8'h1F, 12'hA1E, 5'h1C, 5'h00, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h0, REF, 8'h13, 12'h2EE, 5'h06, 5'h00, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h0, REF, 8'h13, 12'h3DE, 5'h06, 5'h00, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h0, REF, 8'h13, 12'h3E8, 5'h06, 5'h00, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h1, REF, 8'h85, 12'h707, 5'h00, 5'h09, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h1, REF, 8'h13, 12'h578, 5'h00, 5'h09, 8'h01, 8'h01, 1'b0, 1'b0);
		send(2'h2, REF, 8'h17, 12'hA1E, 5'h1C, 5'h00, 8'h01, 8'h01, 1'b1, 1'b0);
		send(2'h3, REF, 8'h17, 12'hA1E, 5'h1C, 5'h00, 8'h01, 8'h02, 1'b1, 1'b0);
		send(2'h3, REF, 8'h17, 12'hA1E, 5'h1C, 5'h00, 8'h01, 8'h02, 1'b0, 1'b1);
		send(2'h1, REF, 8'h6F, 12'h707, 5'h00, 5'h09, 8'h03, 8'h01, 1'b0, 1'b0);
		send(2'h0, REF, 8'h17, 12'hA1E, 5'h1C, 5'h00, 8'h00, 8'h01, 1'b0, 1'b0);
		for (int k = 0; k < 16; k++) begin
			rnd = lfsr_next(rnd);
			ser_out_en = rnd[31];
			send(rnd[1:0], REF + {rnd[31:20], 8'h00}, 8'h14 + rnd[8:2], 12'h3E8 + rnd[18:9],
				rnd[23:19], rnd[27:23], {6'h00, rnd[26:25]}, 8'h01 + rnd[29:28], rnd[30], rnd[12]);
			repeat (3) @(negedge clk_sys);
			chk("eq_stale", 32'(stale_q), 32'h0);
		end
		chk("pending", 32'(exq.size()), 32'h0);
		test_done();
	end
endmodule
